// *** design/pecap_pkg.sv ***
/*
  Package for the express capability block: offsets, field values,
  reset values and the carrier structs.
  Assumes a 32-bit APB slave with byte addresses.
*/
package pecap_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] PECAP_OFF_CAP_HDR = 12'h0b0;
  localparam logic [11:0] PECAP_OFF_DEV_CAP = 12'h0b4;
  localparam logic [11:0] PECAP_OFF_STRAP   = 12'h0c0;

  // ==========================================================
  // capability header fields
  localparam logic [7:0] PECAP_CAP_ID      = 8'h10;
  localparam logic [7:0] PECAP_NEXT_PTR    = 8'hd8;
  localparam logic [3:0] PECAP_CAP_VERSION = 4'h1;
  localparam logic [3:0] PECAP_TYPE_FWD    = 4'h7;
  localparam logic [3:0] PECAP_TYPE_REV    = 4'h8;
  localparam logic [4:0] PECAP_INT_MSG_NUM = 5'h00;

  // ==========================================================
  // device capability fields
  localparam logic [2:0] PECAP_MAX_PAYLOAD = 3'h1;
  localparam logic [1:0] PECAP_PHANTOM     = 2'h0;
  localparam logic       PECAP_TAG8        = 1'b1;
  localparam logic [2:0] PECAP_L0S_LAT     = 3'h0;
  localparam logic [2:0] PECAP_L1_LAT      = 3'h0;
  localparam logic [7:0] PECAP_SPL_VAL_RST = 8'h00;
  localparam logic [1:0] PECAP_SPL_SCL_RST = 2'h0;

  localparam logic [31:0] PECAP_ZERO_WORD  = 32'h0000_0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pecap_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pecap_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } pecap_spl_msg_t;

  typedef struct packed {
    logic       reverse;
    logic       hotplug;
  } pecap_strap_t;

endpackage

// *** design/pecap_strap_latch.sv ***
/*
  Catches the bridge-mode and hot-plug straps once after reset release.
  Assumes straps are steady and synchronous to pclk around reset.
*/
module pecap_strap_latch
  import pecap_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire pecap_strap_t strap_in,
  output pecap_strap_t      strap_out
);

  typedef struct packed {
    logic         caught;
    pecap_strap_t strap;
  } pecap_sl_state_t;

  pecap_sl_state_t st_r;
  pecap_sl_state_t st_nxt;

  // ==========================================================
  // capture on the first edge after release, then hold
  always_comb begin
    st_nxt = st_r;
    if (!st_r.caught) begin
      st_nxt.caught = 1'b1;
      st_nxt.strap  = strap_in;
    end
  end

  // async reset loads constants only; the pin is sampled by the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign strap_out = st_r.strap;

endmodule

// *** design/pecap_spl_capture.sv ***
/*
  Holds the captured slot power limit value and scale.
  Assumes the link layer presents each decoded message as a
  one-cycle valid pulse in the pclk domain.
*/
module pecap_spl_capture
  import pecap_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire pecap_spl_msg_t msg,
  output logic [7:0]          spl_value,
  output logic [1:0]          spl_scale
);

  typedef struct packed {
    logic [7:0] value;
    logic [1:0] scale;
  } pecap_spl_state_t;

  pecap_spl_state_t st_r;
  pecap_spl_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (msg.valid) begin
      st_nxt.value = msg.value; // [R11]
      st_nxt.scale = msg.scale; // [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.value <= PECAP_SPL_VAL_RST; // [R11]
      st_r.scale <= PECAP_SPL_SCL_RST; // [R12]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign spl_value = st_r.value;
  assign spl_scale = st_r.scale;

endmodule

// *** design/pecap_regs.sv ***
/*
  Express capability structure (header word and device capability word)
  read over APB. Everything is read-only; writes to mapped words are
  accepted and dropped. A third word reports the latched straps.
  Assumes a single pclk domain and synchronous strap and message inputs.
*/
// The APB slave port is this design's own decision.
// What this block does
// [R1] header bits 7:0 read capability id 10h
// [R2] header bits 15:8 read next pointer d8h
// [R3] port type 7h forward, 8h reverse
// [R4] slot implemented 0 forward, 1 reverse
// [R5] phantom function bits 4:3 read zero
// [R6] bit 5 reads one: 8-bit tags
// [R7] l0s latency bits 8:6 read 000
// [R8] l1 latency bits 11:9 read 000
// [R9] attention button only with forward hot-plug
// [R10] indicators present only with forward hot-plug
// [R11] power limit value captured from message
// [R12] power limit scale captured from message
// [R13] writes ignored, reserved bits read zero
module pecap_regs
  import pecap_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire pecap_apb_req_t apb_req,
  output pecap_apb_rsp_t      apb_rsp,
  input  wire pecap_strap_t   strap_pins,
  input  wire pecap_spl_msg_t spl_msg
);

  typedef enum logic [0:0] {
    PECAP_IDLE   = 1'b0,
    PECAP_ACCESS = 1'b1
  } pecap_phase_t;

  typedef struct packed {
    pecap_phase_t phase;
    logic         slverr;
    logic [31:0]  rdata;
  } pecap_state_t;

  pecap_state_t st_r;
  pecap_state_t st_nxt;

  pecap_strap_t strap;
  logic [7:0]   spl_value;
  logic [1:0]   spl_scale;
  logic [31:0]  hdr_word;
  logic [31:0]  dev_word;
  logic [31:0]  strap_word;
  logic         hp_fwd;

  // ==========================================================
  // submodules
  pecap_strap_latch pecap_strap_latch_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .strap_in  (strap_pins),
    .strap_out (strap)
  );

  pecap_spl_capture pecap_spl_capture_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .msg       (spl_msg),
    .spl_value (spl_value),
    .spl_scale (spl_scale)
  );

  // ==========================================================
  // word assembly
  // hot-plug pins only exist on the side without a slot, i.e. forward mode
  assign hp_fwd = strap.hotplug & ~strap.reverse;

  always_comb begin
    hdr_word        = PECAP_ZERO_WORD; // [R13]
    hdr_word[7:0]   = PECAP_CAP_ID; // [R1]
    hdr_word[15:8]  = PECAP_NEXT_PTR; // [R2]
    hdr_word[19:16] = PECAP_CAP_VERSION;
    hdr_word[23:20] = strap.reverse ? PECAP_TYPE_REV
                                    : PECAP_TYPE_FWD; // [R3]
    hdr_word[24]    = strap.reverse; // [R4]
    hdr_word[29:25] = PECAP_INT_MSG_NUM;
  end

  always_comb begin
    dev_word        = PECAP_ZERO_WORD; // [R13]
    dev_word[2:0]   = PECAP_MAX_PAYLOAD;
    dev_word[4:3]   = PECAP_PHANTOM; // [R5]
    dev_word[5]     = PECAP_TAG8; // [R6]
    dev_word[8:6]   = PECAP_L0S_LAT; // [R7]
    dev_word[11:9]  = PECAP_L1_LAT; // [R8]
    dev_word[12]    = hp_fwd; // [R9]
    dev_word[13]    = hp_fwd; // [R10]
    dev_word[14]    = hp_fwd; // [R10]
    dev_word[25:18] = spl_value; // [R11]
    dev_word[27:26] = spl_scale; // [R12]
  end

  always_comb begin
    strap_word    = PECAP_ZERO_WORD;
    strap_word[0] = strap.reverse;
    strap_word[1] = strap.hotplug;
  end

  // ==========================================================
  // apb slave: no wait states, pready in the first access cycle, data registered
  always_comb begin
    st_nxt = st_r;
    case (st_r.phase)
      PECAP_IDLE: begin
        if (apb_req.psel && !apb_req.penable) begin
          st_nxt.phase  = PECAP_ACCESS;
          st_nxt.slverr = 1'b0;
          st_nxt.rdata  = PECAP_ZERO_WORD;
          // writes to known words are dropped silently
          if (!apb_req.pwrite) begin // [R13]
            case (apb_req.paddr)
              PECAP_OFF_CAP_HDR: st_nxt.rdata = hdr_word;
              PECAP_OFF_DEV_CAP: st_nxt.rdata = dev_word;
              PECAP_OFF_STRAP:   st_nxt.rdata = strap_word;
              default:           st_nxt.slverr = 1'b1;
            endcase
          end else begin
            case (apb_req.paddr)
              PECAP_OFF_CAP_HDR,
              PECAP_OFF_DEV_CAP,
              PECAP_OFF_STRAP:   st_nxt.slverr = 1'b0;
              default:           st_nxt.slverr = 1'b1;
            endcase
          end
        end
      end
      PECAP_ACCESS: begin
        st_nxt.phase = PECAP_IDLE;
      end
      default: begin
        st_nxt.phase = PECAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.phase  <= PECAP_IDLE;
      st_r.slverr <= 1'b0;
      st_r.rdata  <= PECAP_ZERO_WORD;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    apb_rsp.pready  = (st_r.phase == PECAP_ACCESS);
    apb_rsp.pslverr = (st_r.phase == PECAP_ACCESS) & st_r.slverr;
    apb_rsp.prdata  = st_r.rdata;
  end

endmodule

// *** verif/pecap_regs_sva.sv ***
/* checker for the capability words on pecap_regs ports
   assumes straps only change while presetn is low */
module pecap_regs_sva
  import pecap_pkg::*;
(
  input wire logic           pclk,
  input wire logic           presetn,
  input wire pecap_apb_req_t apb_req,
  input wire pecap_apb_rsp_t apb_rsp,
  input wire pecap_strap_t   strap_pins,
  input wire pecap_spl_msg_t spl_msg
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // helpers
  logic [9:0]  spl_r;
  logic        rd0, rd4, fw, st, um;
  logic [31:0] d;
  assign d   = apb_rsp.prdata;
  assign fw  = strap_pins.hotplug & ~strap_pins.reverse;
  assign st  = apb_req.psel & ~apb_req.penable;
  assign rd0 = apb_rsp.pready & ~apb_req.pwrite & apb_req.paddr == 12'h0b0;
  assign rd4 = apb_rsp.pready & ~apb_req.pwrite & apb_req.paddr == 12'h0b4;
  assign um  = !(apb_req.paddr inside {12'h0b0, 12'h0b4, 12'h0c0});
  // mirror of the last message, so reads need no stimulus knowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      spl_r <= 10'h000;
    else if (spl_msg.valid)
      spl_r <= {spl_msg.scale, spl_msg.value};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  id_next_a: assert property (rd0 |-> d[15:0] == 16'hd810)
    else $error("header id or pointer wrong");
  port_type_a: assert property
    (rd0 |-> d[23:20] == (strap_pins.reverse ? 4'h8 : 4'h7))
    else $error("port type wrong");
  slot_impl_a: assert property (rd0 |-> d[24] == strap_pins.reverse)
    else $error("slot implemented wrong");
  hdr_resv_a: assert property (rd0 |-> d[31:25] == 7'h00)
    else $error("header upper bits not zero");
  tag_lat_a: assert property (rd4 |-> d[11:3] == 9'h004)
    else $error("phantom tag or latency bits wrong");
  hot_plug_a: assert property (rd4 |-> d[14:12] == {3{fw}})
    else $error("hot-plug presence bits wrong");
  spl_cap_a: assert property (rd4 |-> d[27:18] == spl_r)
    else $error("captured power limit wrong");
  unmapped_a: assert property
    (apb_rsp.pready & um |-> apb_rsp.pslverr && d == 32'h0)
    else $error("unmapped access not refused");
  ready_one_a: assert property (st |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("pready not one cycle after setup");
endmodule

bind pecap_regs pecap_regs_sva pecap_regs_sva_i (
  .pclk       (pclk),
  .presetn    (presetn),
  .apb_req    (apb_req),
  .apb_rsp    (apb_rsp),
  .strap_pins (strap_pins),
  .spl_msg    (spl_msg)
);

// *** verif/pecap_cfg_req.sv ***
/* configuration requester model: apb master and power limit messages
   assumes callers enter its tasks just after a rising pclk edge */
module pecap_cfg_req
  import pecap_pkg::*;
(
  input  wire logic           pclk,
  output pecap_apb_req_t      apb_req,
  input  wire pecap_apb_rsp_t apb_rsp,
  output pecap_spl_msg_t      spl_msg
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    apb_req = '0;
    spl_msg = '0;
  end
  // ==========================================================
  // k keeps psel up so the next setup follows at once
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, input logic k);
    apb_req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    // released lines show junk, not the old value
    if (!k)
      apb_req <= {2'h0, ~w, ~a, ~wd};
  endtask
  task automatic spl(input logic [7:0] v, input logic [1:0] s);
    spl_msg <= '{1'b1, v, s};
    @(posedge pclk);
    spl_msg <= '{1'b0, ~v, ~s};
  endtask
endmodule

// *** verif/pecap_regs_tb.sv ***
/* self-checking bench for pecap_regs over all strap settings
   assumes the requester model in pecap_cfg_req.sv */
module pecap_regs_tb import pecap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic           pclk, presetn;
  pecap_apb_req_t apb_req;
  pecap_apb_rsp_t apb_rsp;
  pecap_strap_t   strap_pins;
  pecap_spl_msg_t spl_msg;
  int             failures, compares, seed;
  logic [32:0]    q[$];
  logic [7:0]     v;
  logic [1:0]     s;
  logic [32:0]    hdr;
  pecap_regs pecap_regs_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .strap_pins(strap_pins), .spl_msg(spl_msg));
  pecap_cfg_req pecap_cfg_req_i (.pclk(pclk), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .spl_msg(spl_msg));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================================
  // scoreboard: writes read back zero data and only carry pslverr
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] apb response exp %h got %h", e, g);
    end
  endtask
  always @(posedge pclk) begin
    if (presetn && apb_rsp.pready === 1'b1)
      chk(apb_rsp[32:0], q.pop_front());
  end
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic k);
    q.push_back(e);
    pecap_cfg_req_i.xfer(1'b0, a, 32'h0, k);
  endtask
  task automatic wr(input logic [11:0] a, input logic e);
    q.push_back({e, 32'h0});
    pecap_cfg_req_i.xfer(1'b1, a, $random(seed), 1'b1);
  endtask
  function automatic logic [32:0] dev(input int m, input logic [9:0] c);
    return {5'h00, c, 3'h0, {3{m == 1}}, 9'h004, 3'h1};
  endfunction
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20us;
    failures++;
    finish_test();
  end
  initial begin
    seed = 9286;
    failures = 0;
    compares = 0;
    for (int m = 0; m < 4; m++) begin
      presetn <= 1'b0;
      strap_pins <= m[1:0];
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      hdr = {8'h00, m[1], m[1] ? 4'h8 : 4'h7, 20'h1d810};
      rd(12'h0b0, hdr, 1'b1);
      rd(12'h0b4, dev(m, 10'h000), 1'b1);
      rd(12'h0c0, {31'h0, m[0], m[1]}, 1'b0);
      v = $random(seed);
      s = $random(seed);
      pecap_cfg_req_i.spl(v, s);
      wr(12'h0b4, 1'b0);
      wr(12'h0b0, 1'b0);
      wr(12'h0c8, 1'b1);
      rd(12'h0b4, dev(m, {s, v}), 1'b1);
      rd(12'h0b0, hdr, 1'b1);
      rd(12'h0c4, {1'b1, 32'h0}, 1'b0);
      @(posedge pclk);
      $display("strap setting %0d done", m);
    end
    finish_test();
  end
endmodule
